// file: scl_pkg.sv
// constants and types for the coupler switch and indicator block
// Overview of operation
// RULE1: registration switch off-to-on with unit power records attached module table.
// RULE2: registration switch on-to-off erases the registered module table.
// RULE3: registered table check enforced only while registration switch is on.
// RULE4: auto-restore arms on its rising edge with registration on; off means no restore.
// RULE5: backup fires only on on-off-on of backup switch within 3 s.
// RULE6: the unused second switch is kept off; it has no function.
// RULE7: all switch functions read as off after reset.
// RULE8: backup parameters are internal only, never on the fieldbus path.
// RULE9: after registration leave registration and restore on, backup off.
// RULE10: watchdog timeout gives double flash on error indicator; off without error.
// RULE11: local-error state change gives single flash and sets status error bit.
// RULE12: configuration error blinks; critical error lights steadily, highest priority.
// RULE13: per-port link indicator off without link, on with link, flicker on traffic.
// RULE14: run indicator off, blink, single flash, on for Init, PreOp, SafeOp, Op.
// RULE15: switches synchronised and debounced so each transition gives one edge.
`default_nettype none
package scl_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BACKUP_WIN_MS = 3000;
  localparam int unsigned BACKUP_WIN_CYC = (CLK_HZ / 1000) * BACKUP_WIN_MS;
  localparam int unsigned DEBOUNCE_MS   = 10;
  localparam int unsigned DEBOUNCE_CYC  = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned BLINK_MS      = 200;
  localparam int unsigned BLINK_CYC     = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned FLICKER_MS    = 50;
  localparam int unsigned FLICKER_CYC   = (CLK_HZ / 1000) * FLICKER_MS;
  localparam int unsigned SW_OFF        = 0;
  localparam logic        SW_RESET      = 1'h0;
  localparam int unsigned TABLE_W       = 64;
  localparam logic [TABLE_W-1:0] TABLE_RESET = 64'h0;
  localparam logic [2:0]  PHASE_RESET   = 3'h0;
  // fieldbus slave states as seen by the run indicator
  typedef enum logic [3:0] {
    SCL_INIT   = 4'h1,
    SCL_PREOP  = 4'h2,
    SCL_SAFEOP = 4'h4,
    SCL_OP     = 4'h8
  } scl_slave_t;
  // backup gesture tracker
  typedef enum logic [3:0] {
    SCL_BK_IDLE  = 4'h1,
    SCL_BK_ON1   = 4'h2,
    SCL_BK_OFF   = 4'h4,
    SCL_BK_DONE  = 4'h8
  } scl_bk_t;
endpackage : scl_pkg
`default_nettype wire

// file: scl_debounce.sv
// two-flop synchroniser and debouncer for one switch input
`default_nettype none
module scl_debounce #(
  // settling span in cycles; the package default is the field value
  parameter int unsigned DEBOUNCE = scl_pkg::DEBOUNCE_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic raw,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic        sync_a;
  logic        sync_b;
  logic        stable;
  logic [31:0] cnt;
  logic        next_stable;
  logic [31:0] next_cnt;

  // RULE15 debounce counter
  always_comb begin
    next_stable = stable;
    next_cnt    = 32'h0;
    if (sync_b != stable) begin
      next_cnt = cnt + 32'h1;
      if (cnt >= 32'(DEBOUNCE - 1)) begin
        next_stable = sync_b;
        next_cnt    = 32'h0;
      end
    end
  end

  // RULE7 switches read off from reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_a <= scl_pkg::SW_RESET;
      sync_b <= scl_pkg::SW_RESET;
      stable <= scl_pkg::SW_RESET;
      cnt    <= 32'h0;
      level  <= scl_pkg::SW_RESET;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
      stable <= next_stable;
      cnt    <= next_cnt;
      level  <= next_stable;
      // RULE15 single edge pulse
      rise   <= next_stable & ~stable;
      fall   <= ~next_stable & stable;
    end
  end
endmodule : scl_debounce
`default_nettype wire

// file: scl_top.sv
// switch handling and front-panel indicator logic of the slice coupler
`default_nettype none
module scl_top #(
  parameter int unsigned BACKUP_WIN = scl_pkg::BACKUP_WIN_CYC,
  parameter int unsigned BLINK      = scl_pkg::BLINK_CYC,
  parameter int unsigned FLICKER    = scl_pkg::FLICKER_CYC,
  parameter int unsigned DEBOUNCE   = scl_pkg::DEBOUNCE_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       sw_regs,
  input  wire logic                       sw_unused,
  input  wire logic                       sw_restore,
  input  wire logic                       sw_backup,
  input  wire logic                       unit_power,
  input  wire logic [scl_pkg::TABLE_W-1:0] attached_table,
  input  wire logic                       module_replaced,
  input  wire logic [3:0]                 slave_state,
  input  wire logic                       err_watchdog,
  input  wire logic                       err_local,
  input  wire logic                       err_config,
  input  wire logic                       err_critical,
  input  wire logic                       link_in,
  input  wire logic                       act_in,
  input  wire logic                       link_out,
  input  wire logic                       act_out,
  output logic [scl_pkg::TABLE_W-1:0]     reg_table,
  output logic                            table_check_en,
  output logic                            table_mismatch,
  output logic                            restore_req,
  output logic                            backup_req,
  output logic                            al_err_ind,
  output logic                            led_run,
  output logic                            led_err,
  output logic                            led_la_in,
  output logic                            led_la_out
);
  logic regs_lvl, regs_rise, regs_fall;
  logic rest_lvl, rest_rise, rest_fall;
  logic back_lvl, back_rise, back_fall;

  // one debouncer per switch; the unused switch is sampled but ignored
  scl_debounce #(.DEBOUNCE(DEBOUNCE)) u_regs (.core_clk(core_clk), .rst(rst), .raw(sw_regs),
                                              .level(regs_lvl), .rise(regs_rise), .fall(regs_fall));
  scl_debounce #(.DEBOUNCE(DEBOUNCE)) u_rest (.core_clk(core_clk), .rst(rst), .raw(sw_restore),
                                              .level(rest_lvl), .rise(rest_rise), .fall(rest_fall));
  scl_debounce #(.DEBOUNCE(DEBOUNCE)) u_back (.core_clk(core_clk), .rst(rst), .raw(sw_backup),
                                              .level(back_lvl), .rise(back_rise), .fall(back_fall));
  // RULE6 second switch has no function
  scl_debounce #(.DEBOUNCE(DEBOUNCE)) u_nc   (.core_clk(core_clk), .rst(rst), .raw(sw_unused),
                                              .level(), .rise(), .fall());

  logic pwr_a, pwr_b, rep_a, rep_b;
  logic [7:0] ind_a, ind_b;
  logic [3:0] st_a, st_b;
  // synchronise asynchronous status inputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_a <= 1'b0; pwr_b <= 1'b0;
      rep_a <= 1'b0; rep_b <= 1'b0;
      ind_a <= 8'h0; ind_b <= 8'h0;
      st_a  <= 4'h1; st_b  <= 4'h1;
    end else begin
      pwr_a <= unit_power; pwr_b <= pwr_a;
      rep_a <= module_replaced; rep_b <= rep_a;
      ind_a <= {err_watchdog, err_local, err_config, err_critical, link_in, act_in, link_out, act_out};
      ind_b <= ind_a;
      st_a  <= slave_state; st_b <= st_a;
    end
  end

  // counter helper used by the blink and flicker counters of the indicator timebase
  function automatic logic [31:0] tick(input logic [31:0] c, input int unsigned lim);
    tick = (c >= 32'(lim - 1)) ? 32'h0 : c + 32'h1;
  endfunction : tick

  // registered table, restore arming and backup gesture
  logic [scl_pkg::TABLE_W-1:0] next_reg_table;
  logic                        rest_armed, next_rest_armed;
  logic                        next_restore_req, next_backup_req;
  scl_pkg::scl_bk_t            bk, next_bk;
  logic [31:0]                 bk_cnt, next_bk_cnt;

  always_comb begin
    next_reg_table   = reg_table;
    next_rest_armed  = rest_armed;
    next_restore_req = 1'b0;
    next_backup_req  = 1'b0;
    next_bk          = bk;
    next_bk_cnt      = bk_cnt;
    // RULE1 record table
    if (regs_rise && pwr_b)
      next_reg_table = attached_table;
    // RULE2 clear table
    if (regs_fall)
      next_reg_table = scl_pkg::TABLE_RESET;
    // RULE4 arm restore
    if (rest_rise && regs_lvl)
      next_rest_armed = 1'b1;
    if (!rest_lvl || !regs_lvl)
      next_rest_armed = 1'b0;
    // RULE4 restore on replacement
    // RULE8 parameters stay internal; only a request strobe leaves the block
    if (rest_armed && rest_lvl && regs_lvl && rep_b)
      next_restore_req = 1'b1;
    // RULE5 on-off-on window
    if (bk != scl_pkg::SCL_BK_IDLE)
      next_bk_cnt = bk_cnt + 32'h1;
    case (bk)
      scl_pkg::SCL_BK_IDLE: begin
        next_bk_cnt = 32'h0;
        if (back_rise)
          next_bk = scl_pkg::SCL_BK_ON1;
      end
      scl_pkg::SCL_BK_ON1: begin
        if (back_fall)
          next_bk = scl_pkg::SCL_BK_OFF;
      end
      scl_pkg::SCL_BK_OFF: begin
        if (back_rise)
          next_bk = scl_pkg::SCL_BK_DONE;
      end
      scl_pkg::SCL_BK_DONE: begin
        next_backup_req = 1'b1;
        next_bk         = scl_pkg::SCL_BK_IDLE;
      end
      default: next_bk = scl_pkg::SCL_BK_IDLE;
    endcase
    // RULE5 window expiry restarts gesture
    if (bk != scl_pkg::SCL_BK_IDLE && bk != scl_pkg::SCL_BK_DONE &&
        bk_cnt >= 32'(BACKUP_WIN - 1)) begin
      next_bk     = back_rise ? scl_pkg::SCL_BK_ON1 : scl_pkg::SCL_BK_IDLE;
      next_bk_cnt = 32'h0;
    end
  end

  // RULE7 reset values mean off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_table   <= scl_pkg::TABLE_RESET;
      rest_armed  <= 1'b0;
      restore_req <= 1'b0;
      backup_req  <= 1'b0;
      bk          <= scl_pkg::SCL_BK_IDLE;
      bk_cnt      <= 32'h0;
    end else begin
      reg_table   <= next_reg_table;
      rest_armed  <= next_rest_armed;
      restore_req <= next_restore_req;
      backup_req  <= next_backup_req;
      bk          <= next_bk;
      bk_cnt      <= next_bk_cnt;
    end
  end

  // RULE3 check only while registration on
  logic next_check_en, next_mismatch;
  always_comb begin
    next_check_en = regs_lvl;
    next_mismatch = regs_lvl && (attached_table != reg_table);
  end

  // indicator timebase: phase steps once per blink period, flicker toggles faster
  logic [31:0] bl_cnt, next_bl_cnt, fl_cnt, next_fl_cnt;
  logic [2:0]  phase, next_phase;
  logic        flk, next_flk;
  always_comb begin
    next_bl_cnt = tick(bl_cnt, BLINK);
    next_fl_cnt = tick(fl_cnt, FLICKER);
    next_phase  = (bl_cnt >= 32'(BLINK - 1)) ? phase + 3'h1 : phase;
    next_flk    = (fl_cnt >= 32'(FLICKER - 1)) ? ~flk : flk;
  end

  // patterns: blink alternates, single flash one slot in eight, double two
  logic pat_blink, pat_single, pat_double;
  always_comb begin
    pat_blink  = phase[0];
    pat_single = (phase == 3'h0);
    pat_double = (phase == 3'h0) || (phase == 3'h2);
  end

  logic next_run, next_err, next_la_in, next_la_out, next_al_err;
  always_comb begin
    // RULE14 run indicator by state
    case (st_b)
      scl_pkg::SCL_INIT:   next_run = 1'b0;
      scl_pkg::SCL_PREOP:  next_run = pat_blink;
      scl_pkg::SCL_SAFEOP: next_run = pat_single;
      scl_pkg::SCL_OP:     next_run = 1'b1;
      default:             next_run = 1'b0;
    endcase
    // RULE12 critical wins
    if (ind_b[4])
      next_err = 1'b1;
    // RULE12 configuration blink
    else if (ind_b[5])
      next_err = pat_blink;
    // RULE11 local error flash
    else if (ind_b[6])
      next_err = pat_single;
    // RULE10 watchdog double flash
    else if (ind_b[7])
      next_err = pat_double;
    else
      next_err = 1'b0;
    // RULE11 status error bit
    next_al_err = ind_b[6];
    // RULE13 link and activity
    next_la_in  = ind_b[3] && (ind_b[2] ? flk : 1'b1);
    next_la_out = ind_b[1] && (ind_b[0] ? flk : 1'b1);
  end

  // indicator registers; outputs come straight from flip-flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bl_cnt         <= 32'h0;
      fl_cnt         <= 32'h0;
      phase          <= scl_pkg::PHASE_RESET;
      flk            <= 1'b0;
      led_run        <= 1'b0;
      led_err        <= 1'b0;
      led_la_in      <= 1'b0;
      led_la_out     <= 1'b0;
      al_err_ind     <= 1'b0;
      table_check_en <= 1'b0;
      table_mismatch <= 1'b0;
    end else begin
      bl_cnt         <= next_bl_cnt;
      fl_cnt         <= next_fl_cnt;
      phase          <= next_phase;
      flk            <= next_flk;
      led_run        <= next_run;
      led_err        <= next_err;
      led_la_in      <= next_la_in;
      led_la_out     <= next_la_out;
      al_err_ind     <= next_al_err;
      table_check_en <= next_check_en;
      table_mismatch <= next_mismatch;
    end
  end
endmodule : scl_top
`default_nettype wire

// file: scl_assertions.sv
// checker: port-level properties of the coupler switch and indicator block
`default_nettype none
module scl_assertions #(
  parameter int unsigned BACKUP_WIN = 200,
  parameter int unsigned BLINK      = 8
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [3:0] slave_state,
  input wire logic       err_watchdog,
  input wire logic       err_local,
  input wire logic       err_config,
  input wire logic       err_critical,
  input wire logic       link_in,
  input wire logic       act_in,
  input wire logic       link_out,
  input wire logic       act_out,
  input wire logic       table_check_en,
  input wire logic       restore_req,
  input wire logic       backup_req,
  input wire logic       al_err_ind,
  input wire logic       led_run,
  input wire logic       led_err,
  input wire logic       led_la_in,
  input wire logic       led_la_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // five cycles cover the three-stage input pipeline with margin
  a_err_dark: assert property ((!err_watchdog && !err_local && !err_config && !err_critical) [*5] |-> !led_err)
    else $error("error indicator lit without error");
  a_crit_steady: assert property (err_critical [*5] |-> led_err)
    else $error("critical error not steady");
  a_local_bit: assert property (err_local [*5] |-> al_err_ind)
    else $error("status error bit not set");
  a_run_op: assert property ((slave_state == 4'h8) [*5] |-> led_run)
    else $error("run indicator dark in operational");
  a_run_init: assert property ((slave_state == 4'h1) [*5] |-> !led_run)
    else $error("run indicator lit in init");
  a_link_off: assert property (!link_in [*5] |-> !led_la_in)
    else $error("in-port indicator lit without link");
  a_link_on: assert property ((link_out && !act_out) [*5] |-> led_la_out)
    else $error("out-port indicator dark with idle link");
  a_restore_gate: assert property (restore_req |-> table_check_en)
    else $error("restore without registration on");
  a_reset_off: assert property ($past(rst) |-> !table_check_en && !backup_req && !restore_req)
    else $error("switch function active after reset");
  a_backup_pulse: assert property (backup_req |=> !backup_req)
    else $error("backup request longer than one cycle");
  c_run_op: cover property (led_run && slave_state == 4'h8);
  c_err_crit: cover property (led_err && err_critical);
  c_act_out: cover property (act_out && !led_la_out);
  c_backup: cover property (backup_req);
  c_restore: cover property (restore_req && table_check_en);
endmodule : scl_assertions
bind scl_top scl_assertions #(.BACKUP_WIN(BACKUP_WIN), .BLINK(BLINK)) scl_assertions_inst (
  .core_clk(core_clk), .rst(rst), .slave_state(slave_state), .err_watchdog(err_watchdog),
  .err_local(err_local), .err_config(err_config), .err_critical(err_critical), .link_in(link_in),
  .act_in(act_in), .link_out(link_out), .act_out(act_out), .table_check_en(table_check_en),
  .restore_req(restore_req), .backup_req(backup_req), .al_err_ind(al_err_ind), .led_run(led_run),
  .led_err(led_err), .led_la_in(led_la_in), .led_la_out(led_la_out));
`default_nettype wire

// file: scl_far.sv
// model of the fieldbus master and its links as seen by the coupler
`default_nettype none
module scl_far (
  input  wire logic       core_clk,
  input  wire logic [1:0] st_idx,
  input  wire logic [3:0] err_on,
  input  wire logic [3:0] port_mode,
  output logic [3:0]      slave_state,
  output logic [3:0]      errs,
  output logic [3:0]      ports
);
  timeunit 1ns;
  timeprecision 1ps;
  // activity only on a live link, a real phy never reports traffic without link
  always_ff @(posedge core_clk) begin
    slave_state <= 4'h1 << st_idx;
    errs <= err_on;
    ports <= port_mode & {port_mode[3], port_mode[3], port_mode[1], port_mode[1]};
  end
endmodule : scl_far
`default_nettype wire

// file: tb_scl_top.sv
// self-checking bench for the coupler switch and indicator block
`default_nettype none
module tb_scl_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'h0, rst = 1'h1, sw_regs = 1'h0, sw_restore = 1'h0, sw_backup = 1'h0;
  logic        sw_unused = 1'h0, unit_power = 1'h0, module_replaced = 1'h0;
  logic [63:0] attached_table = 64'h0;
  logic [1:0]  st_idx = 2'h0;
  logic [3:0]  err_on = 4'h0, port_mode = 4'h0, slave_state, errs, ports;
  logic [63:0] reg_table;
  logic        table_check_en, table_mismatch, restore_req, backup_req, al_err_ind;
  logic [3:0]  obs;
  int          err_total = 0, samples_checked = 0;
  initial forever #5 core_clk = ~core_clk;
  scl_far scl_far_inst (.core_clk(core_clk), .st_idx(st_idx), .err_on(err_on), .port_mode(port_mode),
    .slave_state(slave_state), .errs(errs), .ports(ports));
  // short pattern periods keep each indicator window at 64 cycles
  // short settling span lets a switch step settle within 80 cycles
  scl_top #(.BACKUP_WIN(200), .BLINK(8), .FLICKER(4), .DEBOUNCE(64)) scl_top_inst (
    .core_clk(core_clk), .rst(rst), .sw_regs(sw_regs), .sw_unused(sw_unused), .sw_restore(sw_restore),
    .sw_backup(sw_backup), .unit_power(unit_power), .attached_table(attached_table),
    .module_replaced(module_replaced), .slave_state(slave_state), .err_watchdog(errs[0]),
    .err_local(errs[1]), .err_config(errs[2]), .err_critical(errs[3]), .link_in(ports[1]),
    .act_in(ports[0]), .link_out(ports[3]), .act_out(ports[2]), .reg_table(reg_table),
    .table_check_en(table_check_en), .table_mismatch(table_mismatch), .restore_req(restore_req),
    .backup_req(backup_req), .al_err_ind(al_err_ind), .led_run(obs[0]), .led_err(obs[1]),
    .led_la_in(obs[2]), .led_la_out(obs[3]));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  // lit cycles over one full 64-cycle pattern frame, phase does not matter
  task automatic meas(input int sel, output int n);
    repeat (8) @(posedge core_clk);
    n = 0;
    repeat (64) begin
      @(negedge core_clk);
      n += int'(obs[sel] === 1'h1);
    end
  endtask : meas
  task automatic t_reset;
    chk({table_check_en, backup_req, restore_req, obs[1]}, 64'h0);
    chk(reg_table, 64'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_run;
    int ex[4] = '{0, 32, 8, 64};
    int n;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk) st_idx <= 2'(i);
      meas(0, n);
      chk(64'(n), 64'(ex[i]));
    end
    $display("t_run done");
  endtask : t_run
  task automatic t_err;
    logic [3:0] cs[5] = '{4'h1, 4'h2, 4'h4, 4'hf, 4'h0};
    int ex[5] = '{16, 8, 32, 64, 0};
    int n;
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk) err_on <= cs[i];
      meas(1, n);
      chk(64'(n), 64'(ex[i]));
      chk(64'(al_err_ind), 64'(cs[i][1]));
    end
    $display("t_err done");
  endtask : t_err
  task automatic t_link;
    int ex[3] = '{0, 64, 32};
    int n;
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 3; m++) begin
        @(posedge core_clk) port_mode <= 4'((m == 0 ? 0 : (m == 1 ? 2 : 3)) << (2 * p));
        meas(2 + p, n);
        chk(64'(n), 64'(ex[m]));
      end
    $display("t_link done");
  endtask : t_link
  task automatic t_glitch;
    logic seen = 1'h0;
    @(posedge core_clk) begin
      unit_power <= 1'h1;
      attached_table <= 64'h5a5a_0f0f_1234_abcd;
      {sw_regs, sw_restore, sw_backup, module_replaced} <= 4'hf;
    end
    repeat (50) @(negedge core_clk) seen |= table_check_en | backup_req | restore_req;
    @(posedge core_clk) {sw_regs, sw_restore, sw_backup, module_replaced} <= 4'h0;
    repeat (200) @(negedge core_clk) seen |= table_check_en | backup_req | restore_req;
    // bounce of 50 cycles, shorter than the 64-cycle debounce span, yields no edge
    chk(64'(seen), 64'h0);
    chk(reg_table, 64'h0);
    $display("t_glitch done");
  endtask : t_glitch
  // hold one switch setting, counting cycles with a request high at settled sample points
  task automatic drive(input logic [3:0] v, input int cyc, output int nb, output int nr);
    nb = 0;
    nr = 0;
    @(posedge core_clk) {sw_regs, sw_restore, sw_backup, module_replaced} <= v;
    repeat (cyc) begin
      @(negedge core_clk);
      nb += int'(backup_req === 1'h1);
      nr += int'(restore_req === 1'h1);
    end
  endtask : drive
  task automatic t_regs;
    int nb, nr;
    // a rise without unit power records nothing
    @(posedge core_clk) begin
      unit_power <= 1'h0;
      attached_table <= 64'h0123_4567_89ab_cdef;
    end
    drive(4'h8, 80, nb, nr);
    chk(reg_table, 64'h0);
    chk(64'({table_check_en, table_mismatch}), 64'h3);
    drive(4'h0, 80, nb, nr);
    chk(64'({table_check_en, table_mismatch}), 64'h0);
    @(posedge core_clk) unit_power <= 1'h1;
    drive(4'h8, 80, nb, nr);
    chk(reg_table, 64'h0123_4567_89ab_cdef);
    chk(64'({table_check_en, table_mismatch}), 64'h2);
    @(posedge core_clk) attached_table <= 64'h0123_4567_89ab_cdee;
    repeat (3) @(negedge core_clk);
    chk(64'(table_mismatch), 64'h1);
    drive(4'h0, 80, nb, nr);
    chk(reg_table, 64'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_restore;
    int nb, nr;
    // replacement with the restore switch off restores nothing
    drive(4'h9, 80, nb, nr);
    chk(64'(nr), 64'h0);
    drive(4'hc, 80, nb, nr);
    chk(64'(nr), 64'h0);
    // armed restore requests every cycle after the two-stage sync
    drive(4'hd, 20, nb, nr);
    chk(64'(nr), 64'd17);
    drive(4'h9, 80, nb, nr);
    chk(64'(restore_req), 64'h0);
    drive(4'hc, 80, nb, nr);
    chk(64'(nr), 64'h0);
    chk(reg_table, 64'h0123_4567_89ab_cdee);
    drive(4'h0, 80, nb, nr);
    $display("t_restore done");
  endtask : t_restore
  task automatic t_backup;
    int nb, nr, sum;
    // on, off, on well inside the window gives one backup pulse
    drive(4'h2, 80, nb, nr);
    sum = nb;
    drive(4'h0, 80, nb, nr);
    sum += nb;
    drive(4'h2, 80, nb, nr);
    chk(64'(sum), 64'h0);
    chk(64'(nb), 64'h1);
    // the same gesture stretched past the window is abandoned
    sum = 0;
    for (int i = 0; i < 4; i++) begin
      drive((i % 2 == 1) ? 4'h2 : 4'h0, 120, nb, nr);
      sum += nb;
    end
    drive(4'h0, 250, nb, nr);
    sum += nb;
    chk(64'(sum), 64'h0);
    $display("t_backup done");
  endtask : t_backup
  task automatic summarize;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  initial begin
    // about three times the expected run length
    #100000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'h0;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_run();
    t_err();
    t_link();
    t_glitch();
    t_regs();
    t_restore();
    t_backup();
    summarize();
  end
endmodule : tb_scl_top
`default_nettype wire
